// ==== hw/xbu_pkg.sv ====
// Package for the external bus unit: modes, timing fields, config layout.
// Assumes a single 20 MHz core clock; used with package:: scoping only.
package xbu_pkg;

  localparam int NUM_WIN = 4;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int HI_W = 8;
  localparam int CLK_MHZ = 20;
  localparam int CLK_PERIOD_NS = 1000 / CLK_MHZ;

  // Bus mode encoding of a configuration
  localparam logic [1:0] MODE_DEMUX16 = 2'h0;
  localparam logic [1:0] MODE_MUX16 = 2'h1;
  localparam logic [1:0] MODE_MUX8 = 2'h2;
  localparam logic [1:0] MODE_DEMUX8 = 2'h3;

  // Address space restriction encoding
  localparam logic [1:0] SPACE_16M = 2'h0;
  localparam logic [1:0] SPACE_1M = 2'h1;
  localparam logic [1:0] SPACE_256K = 2'h2;
  localparam logic [1:0] SPACE_64K = 2'h3;

  // Upper address lines kept per restriction
  localparam logic [7:0] HI_MASK_16M = 8'hFF;
  localparam logic [7:0] HI_MASK_1M = 8'h0F;
  localparam logic [7:0] HI_MASK_256K = 8'h03;
  localparam logic [7:0] HI_MASK_64K = 8'h00;

  localparam logic [3:0] TIMING_RESET = 4'h0;
  localparam logic [15:0] WIN_SEL_RESET = 16'h0000;

  typedef struct packed {
    logic enable;
    logic [1:0] mode;
    logic [3:0] cycle_wait;
    logic [1:0] tristate_wait;
    logic long_latch;
    logic strobe_delay;
    logic ready_en;
    logic ready_pol;
  } xbu_cfg_t;

  // Window: base in the upper 12 address bits, size as log2 of 4K blocks
  typedef struct packed {
    logic [11:0] base;
    logic [3:0] size;
  } xbu_win_t;

  localparam xbu_cfg_t CFG_RESET = '{1'b0, MODE_DEMUX16, TIMING_RESET,
                                     2'h0, 1'b0, 1'b0, 1'b0, 1'b0};

  typedef struct packed {
    logic req;
    logic write;
    logic [23:0] addr;
    logic [15:0] wdata;
  } xbu_req_t;

endpackage

// ==== hw/xbu_top.sv ====
// External bus unit: runs every external access of the core.
// Assumes core requests are synchronous and held until done_o.
`timescale 1ns/1ns
module xbu_top (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Configuration
  input wire logic single_chip_i,
  input wire xbu_pkg::xbu_cfg_t default_bus_config_i,
  input wire xbu_pkg::xbu_cfg_t [3:0] bus_window_config_i,
  input wire xbu_pkg::xbu_win_t [3:0] address_window_select_i,
  input wire logic [1:0] space_sel_i,
  input wire logic chip_select_timing_bit_i,
  input wire logic arbitration_enable_bit_i,
  input wire logic arbitration_pin_direction_bit_i,
  // Core side
  input wire xbu_pkg::xbu_req_t core_req_i,
  output logic done_o,
  output logic [15:0] rdata_o,
  output logic busy_o,
  // External bus
  output logic [15:0] address_output_port_o,
  output logic [7:0] upper_addr_o,
  output logic [15:0] shared_data_port_o,
  output logic shared_data_port_oe_n_o,
  input wire logic [15:0] shared_data_port_i,
  output logic addr_latch_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic [4:0] chip_select_lines_n_o,
  input wire logic ready_i,
  // Arbitration
  input wire logic hold_req_n_i,
  output logic hold_ack_n_o,
  output logic hold_ack_oe_n_o,
  input wire logic hold_ack_n_i,
  output logic bus_request_out_n_o,
  output logic bus_float_o
);

  typedef enum logic [2:0] {
    ST_IDLE, ST_LATCH, ST_DELAY, ST_STROBE, ST_TRI, ST_HELD
  } xbu_state_t;

  // Highest priority matching window; 4 means none (default region)
  function automatic logic [2:0] pick_window(
    input logic [23:0] a,
    input xbu_pkg::xbu_win_t [3:0] w,
    input xbu_pkg::xbu_cfg_t [3:0] c
  );
    logic [2:0] r;
    logic [3:0] hit;
    logic [11:0] m;
    r = 3'h4;
    for (int i = 0; i < 4; i++) begin
      m = 12'hFFF << w[i].size;
      hit[i] = c[i].enable && ((a[23:12] & m) == (w[i].base & m));
    end
    // Fixed order: 1 beats 0, 3 beats 2, then the upper pair first
    if (hit[3]) begin
      r = 3'h3;
    end else if (hit[2]) begin
      r = 3'h2;
    end else if (hit[1]) begin
      r = 3'h1;
    end else if (hit[0]) begin
      r = 3'h0;
    end
    return r;
  endfunction

  function automatic logic [7:0] hi_mask(input logic [1:0] s);
    logic [7:0] m;
    case (s)
      xbu_pkg::SPACE_1M: m = xbu_pkg::HI_MASK_1M;
      xbu_pkg::SPACE_256K: m = xbu_pkg::HI_MASK_256K;
      xbu_pkg::SPACE_64K: m = xbu_pkg::HI_MASK_64K;
      default: m = xbu_pkg::HI_MASK_16M;
    endcase
    return m;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  xbu_state_t state_reg, state_next;
  xbu_pkg::xbu_cfg_t cfg_reg, cfg_next;
  logic [2:0] win_reg, win_next;
  logic [4:0] cnt_reg, cnt_next;
  logic [23:0] addr_reg, addr_next;
  logic [15:0] wdata_reg, wdata_next;
  logic write_reg, write_next;
  logic done_reg, done_next;
  logic [15:0] rdata_reg, rdata_next;
  logic [15:0] aport_reg, aport_next;
  logic [7:0] upper_reg, upper_next;
  logic [15:0] dport_reg, dport_next;
  logic doe_n_reg, doe_n_next;
  logic ale_reg, ale_next;
  logic rd_n_reg, rd_n_next;
  logic wr_n_reg, wr_n_next;
  logic [4:0] cs_n_reg, cs_n_next;
  logic [4:0] cs_pend_reg, cs_pend_next;
  logic hold_acknowledge_n_reg, hold_acknowledge_n_next;
  logic bus_request_out_n_reg, bus_request_out_n_next;
  logic float_reg, float_next;
  logic hold_oe_n_reg, hold_oe_n_next;

  logic slave_mode;
  logic ready_active;
  logic hold_wanted;
  logic [2:0] win_sel;
  xbu_pkg::xbu_cfg_t cfg_sel;
  logic [4:0] cs_decode;
  logic mux_mode;
  logic byte_mode;

  assign slave_mode = arbitration_pin_direction_bit_i;
  assign hold_wanted = arbitration_enable_bit_i && !slave_mode
                       && !hold_req_n_i;
  assign win_sel = pick_window(core_req_i.addr, address_window_select_i,
                               bus_window_config_i);
  assign cfg_sel = (win_sel == 3'h4) ? default_bus_config_i
                   : bus_window_config_i[win_sel[1:0]];
  assign ready_active = (ready_i == cfg_reg.ready_pol);
  assign mux_mode = (cfg_reg.mode == xbu_pkg::MODE_MUX16) ||
                    (cfg_reg.mode == xbu_pkg::MODE_MUX8);
  assign byte_mode = (cfg_reg.mode == xbu_pkg::MODE_MUX8) ||
                     (cfg_reg.mode == xbu_pkg::MODE_DEMUX8);

  always_comb begin
    cs_decode = 5'h1F;
    cs_decode[win_reg] = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    state_next = state_reg;
    cfg_next = cfg_reg;
    win_next = win_reg;
    cnt_next = cnt_reg;
    addr_next = addr_reg;
    wdata_next = wdata_reg;
    write_next = write_reg;
    done_next = 1'b0;
    rdata_next = rdata_reg;
    aport_next = aport_reg;
    upper_next = upper_reg;
    dport_next = dport_reg;
    doe_n_next = doe_n_reg;
    ale_next = 1'b0;
    rd_n_next = rd_n_reg;
    wr_n_next = wr_n_reg;
    cs_n_next = cs_n_reg;
    cs_pend_next = cs_pend_reg;
    hold_acknowledge_n_next = hold_acknowledge_n_reg;
    bus_request_out_n_next = 1'b1;
    float_next = float_reg;
    hold_oe_n_next = slave_mode;
    // Slave: request the bus while a core access waits for the ack
    if (arbitration_enable_bit_i && slave_mode) begin
      bus_request_out_n_next = !(core_req_i.req && !single_chip_i
                      && hold_ack_n_i);
    end
    // Delayed chip select lands one cycle after latch rise
    if (cs_pend_reg != 5'h1F) begin
      cs_n_next = cs_pend_reg;
      cs_pend_next = 5'h1F;
    end
    case (state_reg)
      ST_IDLE: begin
        if (hold_wanted) begin
          float_next = 1'b1;
          doe_n_next = 1'b1;
          hold_acknowledge_n_next = 1'b0;
          state_next = ST_HELD;
        end else if (core_req_i.req && single_chip_i) begin
          done_next = 1'b1;
        end else if (core_req_i.req && !(arbitration_enable_bit_i &&
                     slave_mode && hold_ack_n_i)) begin
          float_next = 1'b0;
          cfg_next = cfg_sel;
          win_next = win_sel;
          addr_next = core_req_i.addr & {hi_mask(space_sel_i),
                                         16'hFFFF};
          wdata_next = core_req_i.wdata;
          write_next = core_req_i.write;
          cnt_next = {4'h0, cfg_sel.long_latch};
          state_next = ST_LATCH;
        end
      end
      ST_LATCH: begin
        ale_next = 1'b1;
        upper_next = addr_reg[23:16];
        aport_next = addr_reg[15:0];
        if (mux_mode) begin
          dport_next = addr_reg[15:0];
          doe_n_next = 1'b0;
        end else begin
          doe_n_next = !write_reg;
          dport_next = byte_mode ? {8'h00, wdata_reg[7:0]} : wdata_reg;
        end
        // Chip select timed from the latch rise, not from its end
        if (!ale_reg) begin
          if (chip_select_timing_bit_i) begin
            cs_n_next = cs_decode;
          end else begin
            cs_pend_next = cs_decode;
          end
        end
        if (cnt_reg == 5'h0) begin
          cnt_next = {4'h0, cfg_reg.strobe_delay};
          state_next = ST_DELAY;
        end else begin
          cnt_next = cnt_reg - 5'h1;
        end
      end
      ST_DELAY: begin
        if (mux_mode) begin
          doe_n_next = !write_reg;
          dport_next = byte_mode ? {8'h00, wdata_reg[7:0]} : wdata_reg;
        end
        if (cnt_reg == 5'h0) begin
          rd_n_next = write_reg;
          wr_n_next = !write_reg;
          cnt_next = {1'b0, cfg_reg.cycle_wait};
          state_next = ST_STROBE;
        end else begin
          cnt_next = cnt_reg - 5'h1;
        end
      end
      ST_STROBE: begin
        if (cnt_reg != 5'h0) begin
          cnt_next = cnt_reg - 5'h1;
        end else if (!cfg_reg.ready_en || ready_active) begin
          rd_n_next = 1'b1;
          wr_n_next = 1'b1;
          rdata_next = byte_mode ? {8'h00, shared_data_port_i[7:0]}
                       : shared_data_port_i;
          done_next = 1'b1;
          doe_n_next = 1'b1;
          cs_n_next = 5'h1F;
          cnt_next = {3'h0, cfg_reg.tristate_wait};
          state_next = ST_TRI;
        end
      end
      ST_TRI: begin
        if (cnt_reg == 5'h0) begin
          state_next = ST_IDLE;
        end else begin
          cnt_next = cnt_reg - 5'h1;
        end
      end
      ST_HELD: begin
        if (hold_req_n_i || !arbitration_enable_bit_i) begin
          hold_acknowledge_n_next = 1'b1;
          float_next = 1'b0;
          state_next = ST_IDLE;
        end
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_reg <= ST_IDLE;
      cfg_reg <= xbu_pkg::CFG_RESET;
      win_reg <= 3'h4;
      cnt_reg <= 5'h0;
      addr_reg <= 24'h000000;
      wdata_reg <= 16'h0000;
      write_reg <= 1'b0;
      done_reg <= 1'b0;
      rdata_reg <= 16'h0000;
      aport_reg <= 16'h0000;
      upper_reg <= 8'h00;
      dport_reg <= 16'h0000;
      doe_n_reg <= 1'b1;
      ale_reg <= 1'b0;
      rd_n_reg <= 1'b1;
      wr_n_reg <= 1'b1;
      cs_n_reg <= 5'h1F;
      cs_pend_reg <= 5'h1F;
      hold_acknowledge_n_reg <= 1'b1;
      bus_request_out_n_reg <= 1'b1;
      float_reg <= 1'b0;
      hold_oe_n_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cfg_reg <= cfg_next;
      win_reg <= win_next;
      cnt_reg <= cnt_next;
      addr_reg <= addr_next;
      wdata_reg <= wdata_next;
      write_reg <= write_next;
      done_reg <= done_next;
      rdata_reg <= rdata_next;
      aport_reg <= aport_next;
      upper_reg <= upper_next;
      dport_reg <= dport_next;
      doe_n_reg <= doe_n_next;
      ale_reg <= ale_next;
      rd_n_reg <= rd_n_next;
      wr_n_reg <= wr_n_next;
      cs_n_reg <= cs_n_next;
      cs_pend_reg <= cs_pend_next;
      hold_acknowledge_n_reg <= hold_acknowledge_n_next;
      bus_request_out_n_reg <= bus_request_out_n_next;
      float_reg <= float_next;
      hold_oe_n_reg <= hold_oe_n_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Half-cycle chip select delay is rounded up to one full clock here
  assign done_o = done_reg;
  assign rdata_o = rdata_reg;
  assign busy_o = float_reg;
  assign address_output_port_o = aport_reg;
  assign upper_addr_o = upper_reg;
  assign shared_data_port_o = dport_reg;
  assign shared_data_port_oe_n_o = doe_n_reg;
  assign addr_latch_o = ale_reg;
  assign rd_n_o = rd_n_reg;
  assign wr_n_o = wr_n_reg;
  assign chip_select_lines_n_o = cs_n_reg;
  assign hold_ack_n_o = hold_acknowledge_n_reg;
  assign hold_ack_oe_n_o = hold_oe_n_reg;
  assign bus_request_out_n_o = bus_request_out_n_reg;
  assign bus_float_o = float_reg;

endmodule

// ==== dv/xbu_checker.sv ====
// Checker for the external bus unit, bound to xbu_top.
// Assumes one core clock and a synchronous active-high reset.
`timescale 1ns/1ns
module xbu_checker (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Configuration
  input wire logic single_chip_i,
  input wire logic [1:0] space_sel_i,
  input wire logic chip_select_timing_bit_i,
  input wire logic arbitration_enable_bit_i,
  input wire logic arbitration_pin_direction_bit_i,
  // Bus outputs
  input wire logic done_o,
  input wire logic [7:0] upper_addr_o,
  input wire logic shared_data_port_oe_n_o,
  input wire logic addr_latch_o,
  input wire logic rd_n_o,
  input wire logic wr_n_o,
  input wire logic [4:0] chip_select_lines_n_o,
  input wire logic hold_ack_n_o,
  input wire logic hold_ack_oe_n_o,
  input wire logic bus_float_o
);
  logic [7:0] hi_mask;
  logic cs_idle;
  always_comb begin
    case (space_sel_i)
      xbu_pkg::SPACE_1M: hi_mask = xbu_pkg::HI_MASK_1M;
      xbu_pkg::SPACE_256K: hi_mask = xbu_pkg::HI_MASK_256K;
      xbu_pkg::SPACE_64K: hi_mask = xbu_pkg::HI_MASK_64K;
      default: hi_mask = xbu_pkg::HI_MASK_16M;
    endcase
  end
  assign cs_idle = &chip_select_lines_n_o;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////////
  cs_late_a: assert property (
    $rose(addr_latch_o) && !chip_select_timing_bit_i |-> cs_idle ##1 !cs_idle)
    else $error("chip select not one clock after latch");
  cs_early_a: assert property (
    $rose(addr_latch_o) && chip_select_timing_bit_i |-> !cs_idle)
    else $error("chip select not with latch");
  cs_onehot_a: assert property (
    $onehot0(~chip_select_lines_n_o)) else $error("two chip selects");
  upper_mask_a: assert property (
    !cs_idle |-> (upper_addr_o & ~hi_mask) == 8'h00)
    else $error("upper address beyond space");
  hold_float_a: assert property (
    !hold_ack_n_o |-> bus_float_o && rd_n_o && wr_n_o && cs_idle)
    else $error("bus not floated under hold");
  ack_dir_a: assert property (
    !$past(rst_i) && $past(arbitration_enable_bit_i) |->
    hold_ack_oe_n_o == $past(arbitration_pin_direction_bit_i))
    else $error("hold ack direction wrong");
  single_quiet_a: assert property (
    single_chip_i && $past(single_chip_i) |-> rd_n_o && wr_n_o && cs_idle)
    else $error("bus active in single chip");
  read_release_a: assert property (
    !rd_n_o |-> shared_data_port_oe_n_o) else $error("port driven on read");
  done_end_a: assert property (
    done_o && !single_chip_i |-> rd_n_o && wr_n_o ##1 !done_o)
    else $error("done not a clean pulse");
endmodule

bind xbu_top xbu_checker u_checker (.core_clk_i, .rst_i, .single_chip_i,
  .space_sel_i, .chip_select_timing_bit_i, .arbitration_enable_bit_i,
  .arbitration_pin_direction_bit_i, .done_o, .upper_addr_o,
  .shared_data_port_oe_n_o, .addr_latch_o, .rd_n_o, .wr_n_o,
  .chip_select_lines_n_o, .hold_ack_n_o, .hold_ack_oe_n_o, .bus_float_o);

// ==== dv/xbu_mem_model.sv ====
// External memory on the far side of the bus, with a ready output.
// Assumes the bench tells it the mux mode and the ready level and delay.
`timescale 1ns/1ns
module xbu_mem_model (
  // Control from the bench
  input wire logic core_clk_i,
  input wire logic mux_i,
  input wire logic ready_pol_i,
  input wire logic [3:0] ready_wait_i,
  // Bus side
  input wire logic [15:0] addr_i,
  input wire logic [15:0] dout_i,
  input wire logic ale_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic [4:0] cs_n_i,
  output logic [15:0] din_o,
  output logic ready_o
);
  logic [15:0] mem [16];
  logic [3:0] a_reg;
  logic [15:0] last_reg = 16'h0000;
  logic [4:0] cnt_reg;
  // Released port shows a changing pattern, never the last value
  assign din_o = (!rd_n_i && !(&cs_n_i)) ? mem[a_reg] : ~last_reg;
  // No pull-up on ready: inactive level is driven until the delay ends
  assign ready_o = (cnt_reg >= {1'b0, ready_wait_i}) ? ready_pol_i
                                                     : !ready_pol_i;
  always @(posedge core_clk_i) begin
    if (ale_i) a_reg <= mux_i ? dout_i[3:0] : addr_i[3:0];
    if (!wr_n_i && !(&cs_n_i)) mem[a_reg] <= dout_i;
    if (rd_n_i && wr_n_i) cnt_reg <= 5'h00;
    else if (cnt_reg != 5'h1F) cnt_reg <= cnt_reg + 5'h01;
    last_reg <= din_o;
  end
endmodule

// ==== dv/xbu_top_test.sv ====
// Self-checking bench for the external bus unit with a memory model.
// Assumes the design contract: request held until done, one clock domain.
`timescale 1ns/1ns
module xbu_top_test;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic single_chip_i, chip_select_timing_bit_i, arbitration_enable_bit_i;
  logic arbitration_pin_direction_bit_i, hold_req_n_i, hold_ack_n_i;
  logic [1:0] space_sel_i;
  xbu_pkg::xbu_cfg_t default_bus_config_i;
  xbu_pkg::xbu_cfg_t [3:0] bus_window_config_i;
  xbu_pkg::xbu_win_t [3:0] address_window_select_i;
  xbu_pkg::xbu_req_t core_req_i;
  logic done_o, busy_o, shared_data_port_oe_n_o, addr_latch_o, rd_n_o;
  logic wr_n_o, ready_i, hold_ack_n_o, hold_ack_oe_n_o;
  logic bus_request_out_n_o, bus_float_o;
  logic [15:0] rdata_o, address_output_port_o;
  logic [15:0] shared_data_port_o, shared_data_port_i;
  logic [7:0] upper_addr_o, up;
  logic [4:0] chip_select_lines_n_o, csn;
  logic [15:0] rd, ap;
  logic mux = 1'b0;
  logic pol = 1'b0;
  logic [3:0] wt = 4'h0;
  int mismatches = 0;
  int checks_done = 0;
  int lat, cyc = 0;
  logic [23:0] tbl_a [5] = '{24'h000100, 24'h011004, 24'h010004,
                             24'h021008, 24'h020008};
  logic [4:0] tbl_cs [5] = '{5'h0F, 5'h1E, 5'h1D, 5'h1B, 5'h17};
  logic [4:0] tbl_mux = 5'h0A;
  logic [4:0] tbl_b8 = 5'h12;
  logic [7:0] masks [4] = '{xbu_pkg::HI_MASK_16M, xbu_pkg::HI_MASK_1M,
                            xbu_pkg::HI_MASK_256K, xbu_pkg::HI_MASK_64K};

  xbu_top DUT (.core_clk_i, .rst_i, .single_chip_i, .default_bus_config_i,
    .bus_window_config_i, .address_window_select_i, .space_sel_i,
    .chip_select_timing_bit_i, .arbitration_enable_bit_i,
    .arbitration_pin_direction_bit_i, .core_req_i, .done_o, .rdata_o,
    .busy_o, .address_output_port_o, .upper_addr_o, .shared_data_port_o,
    .shared_data_port_oe_n_o, .shared_data_port_i, .addr_latch_o, .rd_n_o,
    .wr_n_o, .chip_select_lines_n_o, .ready_i, .hold_req_n_i, .hold_ack_n_o,
    .hold_ack_oe_n_o, .hold_ack_n_i, .bus_request_out_n_o, .bus_float_o);
  xbu_mem_model u_mem (.core_clk_i, .mux_i(mux), .ready_pol_i(pol),
    .ready_wait_i(wt), .addr_i(address_output_port_o),
    .dout_i(shared_data_port_o), .ale_i(addr_latch_o), .rd_n_i(rd_n_o),
    .wr_n_i(wr_n_o), .cs_n_i(chip_select_lines_n_o),
    .din_o(shared_data_port_i), .ready_o(ready_i));
  ////////////////////////////////////////////////////////////////////////////
  always #25 core_clk_i = ~core_clk_i;
  // About 25 accesses of some 5 to 20 clocks each fit well below this ceiling
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      give_verdict();
    end
  end

  task give_verdict;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH at %0t got %h exp %h", $time, g, e);
    end
  endtask

  // One access: samples 1 ns after each edge, drives 5 ns after it
  task automatic acc(input logic [23:0] a, input logic w,
                     input logic [15:0] d);
    @(posedge core_clk_i);
    #5 core_req_i = '{1'b1, w, a, d};
    lat = 0;
    csn = 5'h1F;
    do begin
      @(posedge core_clk_i);
      #1 lat++;
      csn &= chip_select_lines_n_o;
      if (addr_latch_o) begin
        up = upper_addr_o;
        ap = address_output_port_o;
      end
    end while (done_o !== 1'b1 && lat < 300);
    rd = rdata_o;
    chk(done_o, 1'b1);
    #4 core_req_i.req = 1'b0;
  endtask

  task t_modes;
    logic [15:0] d;
    for (int i = 0; i < 5; i++) begin
      d = 16'hA5C3 + i[15:0];
      mux = tbl_mux[i];
      acc(tbl_a[i], 1'b1, d);
      acc(tbl_a[i], 1'b0, 16'h0000);
      chk(rd, tbl_b8[i] ? {8'h00, d[7:0]} : d);
      chk(csn, tbl_cs[i]);
    end
    // A disabled window must fall back to the default select
    bus_window_config_i[0].enable = 1'b0;
    acc(24'h011004, 1'b0, 16'h0000);
    chk(csn, 5'h0F);
    bus_window_config_i[0].enable = 1'b1;
    mux = 1'b0;
    $display("modes test done");
  endtask

  task t_timing;
    int l0;
    acc(24'h000100, 1'b0, 16'h0000);
    l0 = lat;
    default_bus_config_i.cycle_wait = 4'h5;
    acc(24'h000100, 1'b0, 16'h0000);
    chk(lat - l0, 5);
    default_bus_config_i.cycle_wait = 4'h0;
    default_bus_config_i.long_latch = 1'b1;
    default_bus_config_i.strobe_delay = 1'b1;
    acc(24'h000100, 1'b0, 16'h0000);
    chk(lat - l0, 2);
    default_bus_config_i = xbu_pkg::CFG_RESET;
    // Tri-state time only delays the access that follows
    default_bus_config_i.tristate_wait = 2'h2;
    acc(24'h000100, 1'b0, 16'h0000);
    acc(24'h000100, 1'b0, 16'h0000);
    chk(lat - l0, 2);
    default_bus_config_i = xbu_pkg::CFG_RESET;
    $display("timing test done");
  endtask

  task t_ready;
    bus_window_config_i[1].ready_en = 1'b1;
    wt = 4'h8;
    for (int p = 0; p < 2; p++) begin
      pol = p[0];
      bus_window_config_i[1].ready_pol = p[0];
      acc(24'h010004, 1'b0, 16'h0000);
      chk(lat > 10, 1);
      chk(rd, 16'hA5C5);
    end
    wt = 4'h0;
    bus_window_config_i[1].ready_en = 1'b0;
    $display("ready test done");
  endtask

  task t_space;
    for (int s = 0; s < 4; s++) begin
      space_sel_i = s[1:0];
      chip_select_timing_bit_i = s[0];
      acc(24'hFF0100, 1'b0, 16'h0000);
      chk(up, masks[s]);
      chk(ap, 16'h0100);
    end
    space_sel_i = xbu_pkg::SPACE_16M;
    chip_select_timing_bit_i = 1'b0;
    $display("space test done");
  endtask

  task t_single;
    single_chip_i = 1'b1;
    acc(24'h000100, 1'b1, 16'h1234);
    chk(lat, 1);
    chk(csn, 5'h1F);
    single_chip_i = 1'b0;
    $display("single chip test done");
  endtask

  task t_arb;
    arbitration_enable_bit_i = 1'b1;
    hold_req_n_i = 1'b0;
    repeat (20) begin
      @(posedge core_clk_i);
      #1 if (!hold_ack_n_o) break;
    end
    chk(hold_ack_n_o, 1'b0);
    chk(bus_float_o, 1'b1);
    chk(busy_o, 1'b1);
    fork
      acc(24'h000100, 1'b0, 16'h0000);
      begin
        repeat (15) @(posedge core_clk_i);
        #5 hold_req_n_i = 1'b1;
      end
    join
    chk(lat > 14, 1);
    chk(hold_ack_n_o, 1'b1);
    arbitration_pin_direction_bit_i = 1'b1;
    repeat (3) @(posedge core_clk_i);
    #1 chk(hold_ack_oe_n_o, 1'b1);
    #4 arbitration_pin_direction_bit_i = 1'b0;
    repeat (3) @(posedge core_clk_i);
    #1 chk(hold_ack_oe_n_o, 1'b0);
    // Slave: request the bus and wait for the other master's ack
    #4 arbitration_pin_direction_bit_i = 1'b1;
    fork
      acc(24'h000100, 1'b0, 16'h0000);
      begin
        repeat (4) @(posedge core_clk_i);
        #1 chk(bus_request_out_n_o, 1'b0);
        #4 hold_ack_n_i = 1'b0;
      end
    join
    chk(lat > 4, 1);
    chk(rd, 16'hA5C3);
    hold_ack_n_i = 1'b1;
    $display("arbitration test done");
  endtask

  initial begin
    {single_chip_i, chip_select_timing_bit_i, arbitration_enable_bit_i} = 3'h0;
    arbitration_pin_direction_bit_i = 1'b0;
    hold_req_n_i = 1'b1;
    hold_ack_n_i = 1'b1;
    space_sel_i = xbu_pkg::SPACE_16M;
    core_req_i = '0;
    default_bus_config_i = xbu_pkg::CFG_RESET;
    bus_window_config_i = {4{xbu_pkg::CFG_RESET}};
    for (int i = 0; i < 4; i++) bus_window_config_i[i].enable = 1'b1;
    bus_window_config_i[0].mode = xbu_pkg::MODE_MUX8;
    bus_window_config_i[2].mode = xbu_pkg::MODE_MUX16;
    bus_window_config_i[3].mode = xbu_pkg::MODE_DEMUX8;
    address_window_select_i = {16'h0200, 16'h0211, 16'h0100, 16'h0101};
    repeat (10) @(posedge core_clk_i);
    #5 rst_i = 1'b0;
    t_modes();
    t_timing();
    t_ready();
    t_space();
    t_single();
    t_arb();
    give_verdict();
  end
endmodule
